// file: serial_boot_loader.sv
// Serial boot loader: straps, baud measure, ID, load, hand-off.
//
// Functional notes
// R01: Strap low at reset release enters boot mode.
// R02: Watch receive line for an all-zero byte.
// R03: Derive reload, program channel, enable transmit output.
// R04: Send one identification byte at derived rate.
// R05: Watchdog held disabled while in boot mode.
// R06: After identification, receive first 32 host bytes.
// R07: Store bytes sequentially from load base upward.
// R08: After byte 32 branch to load base.
// R09: Stay in boot mode until next reset.
// R10: Software reset, or strap high, leaves boot mode.
// R11: Exit reset starts at address zero externally; code branches externally only while the access pin is low.
// R12: Bit rate is clock over 32 times reload+1.
// R13: Timer counts quarter clocks; reload=(count-36)/72.
// R14: Host keeps rate deviation below the limit.
// R15: Host rate high enough to avoid timer overflow.
// R16: Host drives the other configuration straps.
// R17: Frames: start, eight data LSB first, stop.

`include "serial_boot_loader_map.svh"

// Byte buffer between the receiver and its consumer.
module boot_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic full;
    logic empty;

    // The extra pointer bit tells a full buffer from an empty one.
    assign empty = (s_r.wr_ptr == s_r.rd_ptr);
    assign full = (s_r.wr_ptr[AW-1:0] == s_r.rd_ptr[AW-1:0]) && (s_r.wr_ptr[AW] != s_r.rd_ptr[AW]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = s_r.mem[s_r.rd_ptr[AW-1:0]];

    // Push and pop may happen in the same cycle.
    always_comb begin
        s_nxt = s_r;
        if (in_valid_i && !full) begin
            s_nxt.mem[s_r.wr_ptr[AW-1:0]] = in_data_i;
            s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
        end
        if (flush_i) begin
            s_nxt.wr_ptr = '0;
            s_nxt.rd_ptr = '0;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end
endmodule

// Boot sequencer with its serial receiver and transmitter.
module serial_boot_loader #(
    parameter logic [7:0] ID_BYTE = 8'h3C, // Arbitrary value; set to the part's own class code.
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sw_reset_i,
    input wire logic boot_strap_pin_i,
    input wire logic config_strap_pin_a_i,
    input wire logic config_strap_pin_b_i,
    input wire logic config_strap_pin_c_i,
    input wire logic external_access_pin_i,
    input wire logic serial_receive_pin_i,
    output logic serial_transmit_pin_o,
    output logic serial_transmit_oe_o,
    output logic serial_boot_mode_o,
    output logic watchdog_disable_o,
    output logic code_access_limit_o,
    output logic [2:0] config_straps_o,
    output logic [15:0] baud_reload_value_o,
    output logic baud_error_o,
    output logic overrun_o,
    output logic frame_error_o,
    input wire logic ram_ready_i,
    output serial_boot_pkg::ram_wr_t ram_wr_o,
    output serial_boot_pkg::branch_t branch_o,
    output serial_boot_pkg::rx_byte_t rx_byte_o,
    input wire logic rx_ready_i
);
    typedef struct packed {
        serial_boot_pkg::boot_state_t st;
        logic rx_m;
        logic rx_s;
        logic rx_prev;
        logic strap_m;
        logic strap_s;
        logic [2:0] cfg_m;
        logic [2:0] cfg_s;
        logic ea_m;
        logic ea_s;
        logic [1:0] settle;
        logic [2:0] cfg_latch;
        logic boot_mode;
        logic [1:0] pre;
        logic [15:0] t6;
        logic [15:0] reload;
        logic baud_err;
        logic [16:0] baud_cnt;
        logic rx_busy;
        logic [3:0] rx_os;
        logic [3:0] rx_slot;
        logic [7:0] rx_shift;
        logic push_valid;
        logic [7:0] push_data;
        logic overrun;
        logic frame_err;
        logic tx_line;
        logic tx_oe;
        logic [9:0] tx_shift;
        logic [3:0] tx_os;
        logic [3:0] tx_bits;
        logic [5:0] load_idx;
        serial_boot_pkg::ram_wr_t ram_wr;
        serial_boot_pkg::branch_t branch;
        serial_boot_pkg::rx_byte_t rx_out;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic baud_run;
    logic tick;
    logic rx_en;
    logic drain_ram;
    logic drain_user;
    logic [15:0] t6_excess;
    logic [15:0] reload_calc;

    // Reload from the measured count; a count under the offset clamps to zero.
    assign t6_excess = (s_r.t6 >= `SBL_T6_OFFSET) ? (s_r.t6 - `SBL_T6_OFFSET) : 16'h0000; // [R13]
    assign reload_calc = t6_excess / `SBL_T6_DIVISOR; // [R13]

    // Oversampling tick: period 2 * (reload + 1) clocks, sixteen per bit.
    assign baud_run = (s_r.st == serial_boot_pkg::ST_SEND_ID) || (s_r.st == serial_boot_pkg::ST_LOAD) ||
                      (s_r.st == serial_boot_pkg::ST_RUN);
    assign tick = baud_run && (s_r.baud_cnt == {s_r.reload, 1'b1}); // [R12]
    assign rx_en = (s_r.st == serial_boot_pkg::ST_LOAD) || (s_r.st == serial_boot_pkg::ST_RUN); // [R06]

    // The buffer drains into RAM during the load and to the loaded code afterwards.
    assign drain_ram = (s_r.st == serial_boot_pkg::ST_LOAD) && fifo_out_valid && ram_ready_i;
    assign drain_user = (s_r.st == serial_boot_pkg::ST_RUN) && fifo_out_valid &&
                        (!s_r.rx_out.valid || rx_ready_i);
    assign fifo_out_ready = drain_ram || drain_user;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ram_wr.we = 1'b0;
        s_nxt.branch.valid = 1'b0;

        // Two-stage synchronisers on every pin input.
        s_nxt.rx_m = serial_receive_pin_i;
        s_nxt.rx_s = s_r.rx_m;
        s_nxt.rx_prev = s_r.rx_s;
        s_nxt.strap_m = boot_strap_pin_i;
        s_nxt.strap_s = s_r.strap_m;
        s_nxt.cfg_m = {config_strap_pin_c_i, config_strap_pin_b_i, config_strap_pin_a_i};
        s_nxt.cfg_s = s_r.cfg_m;
        s_nxt.ea_m = external_access_pin_i;
        s_nxt.ea_s = s_r.ea_m;

        // Baud divider only runs once the rate is known.
        if (!baud_run || tick) begin
            s_nxt.baud_cnt = 17'h00000;
        end else begin
            s_nxt.baud_cnt = s_r.baud_cnt + 17'h00001;
        end

        // A pending byte leaves once the buffer takes it.
        if (s_r.push_valid && fifo_in_ready) begin
            s_nxt.push_valid = 1'b0;
        end

        // Receiver: sample mid-bit; bytes arrive LSB first and need a high stop bit.
        if (rx_en && tick) begin
            if (!s_r.rx_busy) begin
                if (!s_r.rx_s) begin
                    s_nxt.rx_busy = 1'b1;
                    s_nxt.rx_os = 4'h0;
                    s_nxt.rx_slot = 4'h0;
                end
            end else begin
                s_nxt.rx_os = s_r.rx_os + 4'h1;
                if (s_r.rx_os == `SBL_OS_SAMPLE) begin
                    s_nxt.rx_slot = s_r.rx_slot + 4'h1;
                    if (s_r.rx_slot == 4'h0) begin
                        // A start bit that is gone by mid-bit was a glitch.
                        s_nxt.rx_busy = s_r.rx_s ? 1'b0 : 1'b1;
                    end else if (s_r.rx_slot == `SBL_RX_STOP_SLOT) begin
                        s_nxt.rx_busy = 1'b0;
                        if (!s_r.rx_s) begin
                            s_nxt.frame_err = 1'b1; // [R17]
                        end else if (s_nxt.push_valid) begin
                            // The line cannot be paused, so a byte with nowhere to go is lost.
                            s_nxt.overrun = 1'b1;
                        end else begin
                            s_nxt.push_valid = 1'b1;
                            s_nxt.push_data = s_r.rx_shift;
                        end
                    end else begin
                        s_nxt.rx_shift = {s_r.rx_s, s_r.rx_shift[7:1]}; // [R17]
                    end
                end
            end
        end

        // Output register toward the loaded code.
        if (s_r.rx_out.valid && rx_ready_i) begin
            s_nxt.rx_out.valid = 1'b0;
        end
        if (drain_user) begin
            s_nxt.rx_out.valid = 1'b1;
            s_nxt.rx_out.data = fifo_out_data;
        end

        case (s_r.st)
            serial_boot_pkg::ST_STRAP: begin
                // Wait until the synchronised straps are valid, then capture them once.
                if (s_r.settle == `SBL_STRAP_SETTLE) begin
                    s_nxt.cfg_latch = s_r.cfg_s;
                    if (!s_r.strap_s) begin
                        s_nxt.boot_mode = 1'b1; // [R01] [R05]
                        s_nxt.st = serial_boot_pkg::ST_WAIT_ZERO;
                    end else begin
                        s_nxt.st = serial_boot_pkg::ST_NORMAL; // [R10]
                        s_nxt.branch = '{valid: 1'b1, external: ~s_r.ea_s, addr: `SBL_RESET_VECTOR}; // [R11]
                    end
                end else begin
                    s_nxt.settle = s_r.settle + 2'h1;
                end
            end
            serial_boot_pkg::ST_WAIT_ZERO: begin
                // Falling edge of the start bit opens the measurement.
                if (s_r.rx_prev && !s_r.rx_s) begin
                    s_nxt.st = serial_boot_pkg::ST_MEASURE; // [R02]
                    s_nxt.pre = 2'h0;
                    s_nxt.t6 = 16'h0000;
                end
            end
            serial_boot_pkg::ST_MEASURE: begin
                // Nine low bits end at the rising edge of the stop bit.
                if (!s_r.rx_prev && s_r.rx_s) begin
                    s_nxt.reload = reload_calc; // [R03] [R13]
                    s_nxt.baud_err = 1'b0;
                    s_nxt.st = serial_boot_pkg::ST_SEND_ID;
                    s_nxt.tx_oe = 1'b1; // [R03]
                    s_nxt.tx_line = 1'b1;
                    s_nxt.tx_shift = {1'b1, ID_BYTE, 1'b0}; // [R04] [R17]
                    s_nxt.tx_os = 4'h0;
                    s_nxt.tx_bits = 4'h0;
                end else begin
                    s_nxt.pre = s_r.pre + 2'h1;
                    if (s_r.pre == `SBL_T6_PRESCALE_LAST) begin
                        if (s_r.t6 == `SBL_T6_MAX) begin
                            // Host too slow for the timer: report it and wait for another zero byte.
                            s_nxt.baud_err = 1'b1; // [R15]
                            s_nxt.st = serial_boot_pkg::ST_WAIT_ZERO;
                        end else begin
                            s_nxt.t6 = s_r.t6 + 16'h0001; // [R13]
                        end
                    end
                end
            end
            serial_boot_pkg::ST_SEND_ID: begin
                // One idle bit, then start, eight data bits and stop, sixteen ticks each.
                if (tick) begin
                    s_nxt.tx_os = s_r.tx_os + 4'h1;
                    if (s_r.tx_os == `SBL_OS_LAST) begin
                        if (s_r.tx_bits == `SBL_TX_FRAME_BITS) begin
                            s_nxt.st = serial_boot_pkg::ST_LOAD; // [R06]
                            s_nxt.load_idx = 6'h00;
                        end else begin
                            s_nxt.tx_line = s_r.tx_shift[0]; // [R04]
                            s_nxt.tx_shift = {1'b1, s_r.tx_shift[9:1]};
                            s_nxt.tx_bits = s_r.tx_bits + 4'h1;
                        end
                    end
                end
            end
            serial_boot_pkg::ST_LOAD: begin
                // Each byte goes to the next RAM location; the last one triggers the jump.
                if (drain_ram) begin
                    s_nxt.ram_wr.we = 1'b1; // [R07]
                    s_nxt.ram_wr.addr = `SBL_LOAD_BASE + {18'h00000, s_r.load_idx}; // [R07]
                    s_nxt.ram_wr.data = fifo_out_data;
                    s_nxt.load_idx = s_r.load_idx + 6'h01;
                    if (s_r.load_idx == `SBL_LOAD_LAST_IDX) begin
                        s_nxt.st = serial_boot_pkg::ST_RUN; // [R08]
                        s_nxt.branch = '{valid: 1'b1, external: 1'b0, addr: `SBL_LOAD_BASE}; // [R08]
                    end
                end
            end
            serial_boot_pkg::ST_RUN: begin
                // Receiver stays set up for the loaded code; boot mode holds until reset.
                s_nxt.boot_mode = 1'b1; // [R09]
            end
            serial_boot_pkg::ST_NORMAL: begin
                s_nxt.boot_mode = 1'b0;
            end
            default: begin
                s_nxt.st = serial_boot_pkg::ST_STRAP;
            end
        endcase

        // Software reset leaves boot mode whatever the strap says.
        if (sw_reset_i) begin
            s_nxt.st = serial_boot_pkg::ST_NORMAL; // [R10]
            s_nxt.boot_mode = 1'b0;
            s_nxt.tx_oe = 1'b0;
            s_nxt.tx_line = 1'b1;
            s_nxt.rx_busy = 1'b0;
            s_nxt.push_valid = 1'b0;
            s_nxt.rx_out.valid = 1'b0;
            s_nxt.ram_wr.we = 1'b0;
            s_nxt.branch = '{valid: 1'b1, external: ~s_r.ea_s, addr: `SBL_RESET_VECTOR}; // [R11]
        end
    end

    // State register; frozen while the clock enable is low.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // Buffers bytes against a slow RAM port or consumer.
    boot_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .flush_i(sw_reset_i),
        .in_valid_i(s_r.push_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_r.push_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // All outputs come from the state register.
    assign serial_transmit_pin_o = s_r.tx_line;
    assign serial_transmit_oe_o = s_r.tx_oe;
    assign serial_boot_mode_o = s_r.boot_mode;
    assign watchdog_disable_o = s_r.boot_mode; // [R05] [R09]
    assign code_access_limit_o = s_r.boot_mode; // [R09]
    assign config_straps_o = s_r.cfg_latch;
    assign baud_reload_value_o = s_r.reload;
    assign baud_error_o = s_r.baud_err;
    assign overrun_o = s_r.overrun;
    assign frame_error_o = s_r.frame_err;
    assign ram_wr_o = s_r.ram_wr;
    assign branch_o = s_r.branch;
    assign rx_byte_o = s_r.rx_out;
endmodule

// file: serial_boot_loader_map.svh
// Boot loader constants: load window, timing and framing.
`ifndef SERIAL_BOOT_LOADER_MAP_SVH
`define SERIAL_BOOT_LOADER_MAP_SVH

// First and last internal RAM byte written by the initial load.
`define SBL_LOAD_BASE 24'h00FA40
`define SBL_LOAD_LAST 24'h00FA5F
// Number of bytes in the initial load, and the index of the last one.
`define SBL_LOAD_BYTES 6'h20
`define SBL_LOAD_LAST_IDX 6'h1F
// Start address after a reset that ends boot mode.
`define SBL_RESET_VECTOR 24'h000000

// The measuring timer advances once every four clocks.
`define SBL_T6_PRESCALE_LAST 2'h3
`define SBL_T6_MAX 16'hFFFF
// Reload value is (count - 36) / 72.
`define SBL_T6_OFFSET 16'h0024
`define SBL_T6_DIVISOR 16'h0048

// Sixteen ticks per bit; a tick lasts 2 * (reload + 1) clocks.
`define SBL_OS_LAST 4'hF
`define SBL_OS_SAMPLE 4'h7
// Receive bit slots: 0 start, 1..8 data, 9 stop.
`define SBL_RX_STOP_SLOT 4'h9
// Transmit: one idle bit, then ten frame bits.
`define SBL_TX_FRAME_BITS 4'hA

// Clocks to wait after reset release before the synchronised strap is valid.
`define SBL_STRAP_SETTLE 2'h2

`endif

// file: serial_boot_pkg.sv
// Types shared by the serial boot loader and its users.
package serial_boot_pkg;

    // Sequencer states, Gray coded along the boot path.
    typedef enum logic [2:0] {
        ST_STRAP     = 3'h0,
        ST_WAIT_ZERO = 3'h1,
        ST_MEASURE   = 3'h3,
        ST_SEND_ID   = 3'h2,
        ST_LOAD      = 3'h6,
        ST_RUN       = 3'h7,
        ST_NORMAL    = 3'h5
    } boot_state_t;

    // One write into internal RAM.
    typedef struct packed {
        logic we;
        logic [23:0] addr;
        logic [7:0] data;
    } ram_wr_t;

    // Request to start execution at an address.
    typedef struct packed {
        logic valid;
        logic external;
        logic [23:0] addr;
    } branch_t;

    // One received byte handed to the loaded code.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_byte_t;

endpackage

// file: boot_host_model.sv
// Host model of the boot link.
module boot_host_model (
    input wire logic clk_i,
    output logic rxd_o,
    input wire logic txd_i,
    input wire logic tx_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle high, so no false start bit.
    initial rxd_o = 1'b1;

    // Start, eight data bits LSB first, stop; one bit period each.
    task automatic send_byte(input logic [7:0] b, input int bit_clk);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o = frame[i];
            repeat (bit_clk) @(negedge clk_i);
        end
    endtask

    // Waits for a driven start bit, then samples mid-bit.
    // Half duplex: listens only while not sending.
    task automatic recv_byte(input int bit_clk, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (!(tx_oe_i === 1'b1 && txd_i === 1'b0) && n < 40 * bit_clk) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 40 * bit_clk) begin
            return;
        end
        repeat (bit_clk / 2) @(negedge clk_i);
        ok = (txd_i === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clk) @(negedge clk_i);
            b[i] = txd_i;
        end
        repeat (bit_clk) @(negedge clk_i);
        ok = ok && (txd_i === 1'b1);
    endtask
endmodule

// file: serial_boot_loader_sva.sv
// Checker bound to the boot loader top.
`include "serial_boot_loader_map.svh"

module serial_boot_loader_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sw_reset_i,
    input wire logic serial_transmit_pin_o,
    input wire logic serial_transmit_oe_o,
    input wire logic serial_boot_mode_o,
    input wire logic watchdog_disable_o,
    input wire logic code_access_limit_o,
    input wire serial_boot_pkg::ram_wr_t ram_wr_o,
    input wire serial_boot_pkg::branch_t branch_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic [23:0] prev_addr_r;
    logic prev_seen_r;

    // Last RAM address written, to chain each write to the one before.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_addr_r <= 24'h000000;
            prev_seen_r <= 1'b0;
        end else if (ram_wr_o.we) begin
            prev_addr_r <= ram_wr_o.addr;
            prev_seen_r <= 1'b1;
        end
    end

    chk_boot_stays: assert property (serial_boot_mode_o && !sw_reset_i |=> serial_boot_mode_o)
        else $error("boot mode lost");
    chk_wd_level: assert property (watchdog_disable_o == serial_boot_mode_o
            && code_access_limit_o == serial_boot_mode_o)
        else $error("watchdog level wrong");
    chk_sw_exit: assert property (ce_i && sw_reset_i |=> !serial_boot_mode_o && !serial_transmit_oe_o)
        else $error("no sw exit");
    chk_sw_branch: assert property (ce_i && sw_reset_i |=> branch_o.valid && branch_o.addr == `SBL_RESET_VECTOR)
        else $error("no sw branch");
    chk_oe_boot: assert property (serial_transmit_oe_o |-> serial_boot_mode_o)
        else $error("tx oe outside boot");
    chk_tx_idle: assert property ($rose(serial_transmit_oe_o) |-> serial_transmit_pin_o)
        else $error("tx not idle");
    chk_ram_window: assert property (ram_wr_o.we |-> serial_boot_mode_o && ram_wr_o.addr <= `SBL_LOAD_LAST)
        else $error("write outside window");
    chk_ram_order: assert property (ram_wr_o.we
            |-> ram_wr_o.addr == (prev_seen_r ? prev_addr_r + 24'h000001 : `SBL_LOAD_BASE))
        else $error("write out of order");
    chk_load_branch: assert property (branch_o.valid && branch_o.addr == `SBL_LOAD_BASE
            |-> ram_wr_o.we && ram_wr_o.addr == `SBL_LOAD_LAST && !branch_o.external)
        else $error("bad load branch");
    chk_exit_vector: assert property (branch_o.valid && branch_o.addr != `SBL_LOAD_BASE
            |-> branch_o.addr == `SBL_RESET_VECTOR && !serial_boot_mode_o)
        else $error("bad exit branch");
    chk_branch_pulse: assert property (branch_o.valid && !sw_reset_i |=> !branch_o.valid)
        else $error("branch too long");

    // Covers: ID transmit start, load done, software exit.
    cover property ($rose(serial_transmit_oe_o));
    cover property (branch_o.valid && branch_o.addr == `SBL_LOAD_BASE);
    cover property (sw_reset_i ##1 branch_o.valid);
endmodule

bind serial_boot_loader serial_boot_loader_sva u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sw_reset_i(sw_reset_i),
    .serial_transmit_pin_o(serial_transmit_pin_o), .serial_transmit_oe_o(serial_transmit_oe_o),
    .serial_boot_mode_o(serial_boot_mode_o), .watchdog_disable_o(watchdog_disable_o),
    .code_access_limit_o(code_access_limit_o), .ram_wr_o(ram_wr_o), .branch_o(branch_o)
);

// file: serial_boot_loader_bench.sv
// Bench for the serial boot loader.
`include "serial_boot_loader_map.svh"

module serial_boot_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] ID = 8'h3C; // Arbitrary value.
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic sw_reset_i = 1'b0;
    logic boot_strap_pin_i = 1'b1;
    logic config_strap_pin_a_i = 1'b0, config_strap_pin_b_i = 1'b0, config_strap_pin_c_i = 1'b0;
    logic external_access_pin_i = 1'b0;
    logic ram_ready_i = 1'b1;
    logic rx_ready_i = 1'b1;
    logic serial_receive_pin_i, serial_transmit_pin_o, serial_transmit_oe_o, serial_boot_mode_o;
    logic watchdog_disable_o, code_access_limit_o, baud_error_o, overrun_o, frame_error_o;
    logic [2:0] config_straps_o;
    logic [15:0] baud_reload_value_o;
    serial_boot_pkg::ram_wr_t ram_wr_o;
    serial_boot_pkg::branch_t branch_o;
    serial_boot_pkg::rx_byte_t rx_byte_o;
    int n_mismatch = 0;
    int compares = 0;
    serial_boot_pkg::ram_wr_t wr_q[$];
    serial_boot_pkg::branch_t br_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] exp_q[$];

    initial forever #5 clk_i = ~clk_i;

    serial_boot_loader #(.ID_BYTE(ID), .FIFO_DEPTH(16)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sw_reset_i(sw_reset_i),
        .boot_strap_pin_i(boot_strap_pin_i), .config_strap_pin_a_i(config_strap_pin_a_i),
        .config_strap_pin_b_i(config_strap_pin_b_i), .config_strap_pin_c_i(config_strap_pin_c_i),
        .external_access_pin_i(external_access_pin_i), .serial_receive_pin_i(serial_receive_pin_i),
        .serial_transmit_pin_o(serial_transmit_pin_o), .serial_transmit_oe_o(serial_transmit_oe_o),
        .serial_boot_mode_o(serial_boot_mode_o), .watchdog_disable_o(watchdog_disable_o),
        .code_access_limit_o(code_access_limit_o), .config_straps_o(config_straps_o),
        .baud_reload_value_o(baud_reload_value_o), .baud_error_o(baud_error_o), .overrun_o(overrun_o),
        .frame_error_o(frame_error_o), .ram_ready_i(ram_ready_i), .ram_wr_o(ram_wr_o),
        .branch_o(branch_o), .rx_byte_o(rx_byte_o), .rx_ready_i(rx_ready_i)
    );

    boot_host_model i_host (
        .clk_i(clk_i), .rxd_o(serial_receive_pin_i), .txd_i(serial_transmit_pin_o),
        .tx_oe_i(serial_transmit_oe_o)
    );

    // Records RAM writes, branches and taken user bytes.
    always @(posedge clk_i) begin
        if (ram_wr_o.we === 1'b1) wr_q.push_back(ram_wr_o);
        if (branch_o.valid === 1'b1) br_q.push_back(branch_o);
        if (rx_byte_o.valid === 1'b1 && rx_ready_i === 1'b1) rx_q.push_back(rx_byte_o.data);
    end

    // Random stalls make the byte buffer hold data.
    always @(negedge clk_i) begin
        ram_ready_i <= ($urandom % 4) != 0;
        rx_ready_i <= ($urandom % 2) != 0;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Expected reload from nine bit times counted in four-clock steps.
    function automatic logic [15:0] exp_reload(input int bit_clk);
        int count;
        count = (9 * bit_clk) / 4;
        return 16'((count - 36) / 72);
    endfunction

    // Hardware reset with given strap levels; config straps random.
    task automatic hw_reset(input logic strap, input logic ea);
        @(negedge clk_i);
        boot_strap_pin_i = strap;
        external_access_pin_i = ea;
        {config_strap_pin_c_i, config_strap_pin_b_i, config_strap_pin_a_i} = 3'($urandom);
        rst_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        br_q.delete();
        repeat (10) @(negedge clk_i);
        check(32'(config_straps_o), 32'({config_strap_pin_c_i, config_strap_pin_b_i, config_strap_pin_a_i}));
        check(32'(serial_boot_mode_o), 32'(!strap));
        check(32'(watchdog_disable_o), 32'(!strap));
    endtask

    // Watchdog: a boot takes under 60000 clocks.
    initial begin
        #700_000;
        n_mismatch++;
        summarize();
    end

    initial begin
        logic [7:0] id_seen, b;
        logic ok;
        int rl, bit_clk;
        void'($urandom(84315));
        hw_reset(1'b1, 1'b1);
        check(32'(br_q.size()), 32'h1);
        if (br_q.size() > 0) check(32'({br_q[0].external, br_q[0].addr}), 32'({1'b0, `SBL_RESET_VECTOR}));
        hw_reset(1'b0, 1'b0);
        check(32'({serial_transmit_oe_o, br_q.size() != 0}), 32'h0);
        rl = 1 + $urandom % 3;
        bit_clk = 32 * (rl + 1);
        i_host.send_byte(8'h00, bit_clk);
        i_host.recv_byte(bit_clk, id_seen, ok);
        check(32'(ok), 32'h1);
        check(32'(id_seen), 32'(ID));
        check(32'(serial_transmit_oe_o), 32'h1);
        check(32'({baud_error_o, baud_reload_value_o}), 32'(exp_reload(bit_clk)));
        repeat (bit_clk) @(negedge clk_i);
        // 32 load bytes, two for the loaded code; edge values at both ends.
        for (int k = 0; k < 34; k++) begin
            b = 8'($urandom);
            if (k == 0) b = 8'h80;
            if (k == 31) b = 8'h01;
            exp_q.push_back(b);
            i_host.send_byte(b, bit_clk);
        end
        repeat (4 * bit_clk) @(negedge clk_i);
        check(32'(wr_q.size()), 32'h20);
        foreach (wr_q[k]) check(32'({wr_q[k].addr, wr_q[k].data}), 32'({24'(`SBL_LOAD_BASE + k), exp_q[k]}));
        check(32'(br_q.size()), 32'h1);
        if (br_q.size() > 0) check(32'({br_q[0].external, br_q[0].addr}), 32'({1'b0, `SBL_LOAD_BASE}));
        check(32'(rx_q.size()), 32'h2);
        foreach (rx_q[k]) check(32'(rx_q[k]), 32'(exp_q[32 + k]));
        check(32'({serial_boot_mode_o, overrun_o, frame_error_o}), 32'h4);
        // Software reset exits with the strap still low.
        br_q.delete();
        sw_reset_i = 1'b1;
        @(negedge clk_i);
        sw_reset_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check(32'({serial_boot_mode_o, serial_transmit_oe_o}), 32'h0);
        check(32'(br_q.size()), 32'h1);
        if (br_q.size() > 0) check(32'(br_q[0].addr), 32'(`SBL_RESET_VECTOR));
        summarize();
    end
endmodule
